// ---- verilog/amg_pkg.sv ----
// amg_pkg: types and constants for the addressing mode address generator
// assumes an 8-bit core with a 16-bit data space and page zero at 0000h
package amg_pkg;

  // seventeen operand addressing modes, named in their X / direct form
  typedef enum logic [4:0] {
    AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L,
    AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_D, AM_REL_I,
    AM_BIT_D, AM_BIT_I, AM_BIT_DR, AM_BIT_IR
  } amg_mode_t;

  // prebyte that preceded the opcode
  typedef enum logic [1:0] {
    PRE_NONE, y_substitute_prefix, indirect_prefix, y_indirect_prefix
  } amg_pre_t;

  // one decode request, handed over with the bytes after the opcode
  typedef struct packed {
    amg_mode_t mode;
    amg_pre_t pre;
    logic rmw;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] next_pc;
  } amg_req_t;

  // decode answer
  typedef struct packed {
    amg_mode_t mode;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] operand;
    logic [2:0] len;
    logic bad_combo;
    logic rmw_bad;
  } amg_res_t;

  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [2:0] LEN_OPCODE = 3'h1;
  localparam logic [2:0] LEN_PREBYTE = 3'h1;
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;

endpackage : amg_pkg

// ---- verilog/amg_addr_gen.sv ----
// amg_addr_gen: effective address and length decode for all operand modes
// assumes the fetch unit supplies the bytes after the opcode with the
// request, and a same-clock data memory port answers pointer reads with ack
//
// Behaviour
// - seventeen modes in seven families are decoded
// - long forms reach 64K; long direct and indexed cost more bytes
// - short direct and indirect forms reach page zero only
// - read-modify-write accepts short forms only
// - inherent is one byte, opcode only
// - immediate is two bytes, second is operand
// - short direct: one address byte, 00 to FF
// - long direct: address word anywhere in 64K
// - indexed address is unsigned index plus offset
// - no-offset indexed uses index alone, 00-FF
// - Y no-offset form is one byte longer
// - short indexed: offset byte plus index, 1FE
// - long indexed: offset word plus index
// - short indirect: page-zero byte pointer
// - long indirect: page-zero word pointer
// - indirect indexed: pointer plus index register
// - short indirect indexed reaches 00 to 1FE
// - long indirect indexed reaches full 64K
// - relative targets span PC-128 to PC+127
// - three prebytes alter index and indirection
`timescale 1ns/1ps
module amg_addr_gen (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire amg_pkg::amg_req_t REQ,
  output logic MEM_RD,
  output logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic RES_VALID,
  output amg_pkg::amg_res_t RES
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PTR0 = 2'b01, ST_PTR1 = 2'b11, ST_DONE = 2'b10
  } amg_state_t;

  amg_state_t state_q, state_d;
  amg_pkg::amg_req_t req_q;
  amg_pkg::amg_mode_t mode_d, mode_q;
  logic bad_d, bad_q;
  logic [15:0] ptr_q, ptr_d;
  logic [15:0] addr_q;
  amg_pkg::amg_res_t res_q, res_d;
  logic needs_ptr, word_ptr;
  logic [7:0] idx;
  logic [15:0] ea16, tgt;
  logic [2:0] oplen;

  // prebyte remaps the X / direct form onto the indirect form
  always_comb begin
    mode_d = REQ.mode;
    bad_d = 1'b0;
    unique case (REQ.pre)
      amg_pkg::indirect_prefix: begin
        unique case (REQ.mode)
          amg_pkg::AM_DIR_S: mode_d = amg_pkg::AM_IND_S;
          amg_pkg::AM_DIR_L: mode_d = amg_pkg::AM_IND_L;
          amg_pkg::AM_IDX_S: mode_d = amg_pkg::AM_IIX_S;
          amg_pkg::AM_IDX_L: mode_d = amg_pkg::AM_IIX_L;
          amg_pkg::AM_REL_D: mode_d = amg_pkg::AM_REL_I;
          amg_pkg::AM_BIT_D: mode_d = amg_pkg::AM_BIT_I;
          amg_pkg::AM_BIT_DR: mode_d = amg_pkg::AM_BIT_IR;
          default: bad_d = 1'b1;
        endcase
      end
      amg_pkg::y_indirect_prefix: begin
        unique case (REQ.mode)
          amg_pkg::AM_IDX_S: mode_d = amg_pkg::AM_IIX_S;
          amg_pkg::AM_IDX_L: mode_d = amg_pkg::AM_IIX_L;
          default: bad_d = 1'b1;
        endcase
      end
      default: mode_d = REQ.mode;
    endcase
  end

  // pointer fetch is needed only by the indirect families
  always_comb begin
    unique case (mode_q)
      amg_pkg::AM_IND_S, amg_pkg::AM_IIX_S, amg_pkg::AM_REL_I,
      amg_pkg::AM_BIT_I, amg_pkg::AM_BIT_IR: begin
        needs_ptr = 1'b1;
        word_ptr = 1'b0;
      end
      amg_pkg::AM_IND_L, amg_pkg::AM_IIX_L: begin
        needs_ptr = 1'b1;
        word_ptr = 1'b1;
      end
      default: begin
        needs_ptr = 1'b0;
        word_ptr = 1'b0;
      end
    endcase
  end

  // either prebyte that names Y selects the Y index
  assign idx = (req_q.pre == amg_pkg::y_substitute_prefix ||
                req_q.pre == amg_pkg::y_indirect_prefix) ? req_q.y
                                                         : req_q.x;

  // next state: pointer high byte first, then low byte
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (REQ_VALID) state_d = ST_PTR0;
      ST_PTR0: begin
        if (!needs_ptr) state_d = ST_DONE;
        else if (MEM_ACK) state_d = word_ptr ? ST_PTR1 : ST_DONE;
      end
      ST_PTR1: if (MEM_ACK) state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge MCLK) begin
    if (!RST_N) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // request capture
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      req_q <= '0;
      mode_q <= amg_pkg::AM_INH;
      bad_q <= 1'b0;
    end else if (state_q == ST_IDLE && REQ_VALID) begin
      req_q <= REQ;
      mode_q <= mode_d;
      bad_q <= bad_d;
    end
  end

  // pointer assembly, big-endian word
  always_comb begin
    ptr_d = ptr_q;
    if (state_q == ST_PTR0 && needs_ptr && MEM_ACK)
      ptr_d = word_ptr ? {MEM_RDATA, amg_pkg::PAGE_ZERO_HI}
                       : {amg_pkg::PAGE_ZERO_HI, MEM_RDATA};
    else if (state_q == ST_PTR1 && MEM_ACK)
      ptr_d = {ptr_q[15:8], MEM_RDATA};
  end

  // pointer register
  always_ff @(posedge MCLK) begin
    if (!RST_N) ptr_q <= '0;
    else ptr_q <= ptr_d;
  end

  // pointer address: the byte after the opcode in page zero, plus one for the second byte
  always_ff @(posedge MCLK) begin
    if (!RST_N) addr_q <= '0;
    else if (state_q == ST_IDLE)
      addr_q <= {amg_pkg::PAGE_ZERO_HI, REQ.b1};
    else if (state_q == ST_PTR0 && MEM_ACK)
      addr_q <= addr_q + amg_pkg::PTR_STEP;
  end

  assign MEM_ADDR = addr_q;
  assign MEM_RD = needs_ptr && (state_q == ST_PTR0 || state_q == ST_PTR1);

  // effective address and branch target per mode
  always_comb begin
    ea16 = '0;
    tgt = req_q.next_pc;
    oplen = amg_pkg::LEN_NONE;
    unique case (mode_q)
      amg_pkg::AM_INH: oplen = amg_pkg::LEN_NONE;
      amg_pkg::AM_IMM: oplen = amg_pkg::LEN_BYTE;
      amg_pkg::AM_DIR_S: begin
        ea16 = {amg_pkg::PAGE_ZERO_HI, req_q.b1};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_DIR_L: begin
        ea16 = {req_q.b1, req_q.b2};
        oplen = amg_pkg::LEN_WORD;
      end
      amg_pkg::AM_IDX0: ea16 = {amg_pkg::PAGE_ZERO_HI, idx};
      amg_pkg::AM_IDX_S: begin
        ea16 = {7'h00, {1'b0, req_q.b1} + {1'b0, idx}};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_IDX_L: begin
        ea16 = {req_q.b1, req_q.b2} + {8'h00, idx};
        oplen = amg_pkg::LEN_WORD;
      end
      amg_pkg::AM_IND_S, amg_pkg::AM_IND_L: begin
        ea16 = ptr_d;
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_IIX_S: begin
        ea16 = {7'h00, {1'b0, ptr_d[7:0]} + {1'b0, idx}};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_IIX_L: begin
        ea16 = ptr_d + {8'h00, idx};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_REL_D: begin
        tgt = req_q.next_pc + {{8{req_q.b1[7]}}, req_q.b1};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_REL_I: begin
        tgt = req_q.next_pc + {{8{ptr_d[7]}}, ptr_d[7:0]};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_BIT_D: begin
        ea16 = {amg_pkg::PAGE_ZERO_HI, req_q.b1};
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_BIT_I: begin
        ea16 = ptr_d;
        oplen = amg_pkg::LEN_BYTE;
      end
      amg_pkg::AM_BIT_DR: begin
        ea16 = {amg_pkg::PAGE_ZERO_HI, req_q.b1};
        tgt = req_q.next_pc + {{8{req_q.b2[7]}}, req_q.b2};
        oplen = amg_pkg::LEN_WORD;
      end
      amg_pkg::AM_BIT_IR: begin
        ea16 = ptr_d;
        tgt = req_q.next_pc + {{8{req_q.b2[7]}}, req_q.b2};
        oplen = amg_pkg::LEN_WORD;
      end
      default: oplen = amg_pkg::LEN_NONE;
    endcase
  end

  // answer assembly; long forms refused for read-modify-write
  always_comb begin
    res_d.mode = mode_q;
    res_d.ea = ea16;
    res_d.target = tgt;
    res_d.operand = req_q.b1;
    res_d.len = amg_pkg::LEN_OPCODE + oplen +
                ((req_q.pre == amg_pkg::PRE_NONE) ? amg_pkg::LEN_NONE
                                                  : amg_pkg::LEN_PREBYTE);
    res_d.bad_combo = bad_q;
    res_d.rmw_bad = req_q.rmw &&
                    (mode_q == amg_pkg::AM_DIR_L ||
                     mode_q == amg_pkg::AM_IDX_L ||
                     mode_q == amg_pkg::AM_IND_L ||
                     mode_q == amg_pkg::AM_IIX_L);
  end

  // answer register, loaded on the way into the done state
  always_ff @(posedge MCLK) begin
    if (!RST_N) res_q <= '0;
    else if (state_d == ST_DONE && state_q != ST_DONE) res_q <= res_d;
  end

  assign RES = res_q;
  assign RES_VALID = (state_q == ST_DONE);
  assign REQ_READY = (state_q == ST_IDLE);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_take;
    REQ_VALID && REQ_READY;
  endsequence
  sequence s_ptr_done;
    MEM_RD && MEM_ACK;
  endsequence

  a_short_dir_page: assert property (
    RES_VALID && RES.mode == amg_pkg::AM_DIR_S |-> RES.ea[15:8] == 8'h00)
    else $error("short direct left page zero");
  a_short_idx_span: assert property (
    RES_VALID && RES.mode == amg_pkg::AM_IDX_S |-> RES.ea <= 16'h01FE)
    else $error("short indexed out of span");
  a_inh_length: assert property (
    RES_VALID && RES.mode == amg_pkg::AM_INH && $past(req_q.pre,1) ==
    amg_pkg::PRE_NONE |-> RES.len == 3'h1)
    else $error("inherent length not one");
  a_imm_operand: assert property (
    RES_VALID && RES.mode == amg_pkg::AM_IMM |->
    RES.operand == req_q.b1 && RES.len >= 3'h2)
    else $error("immediate operand or length wrong");
  a_direct_no_mem: assert property (
    s_take ##1 (mode_q == amg_pkg::AM_DIR_L) |-> !MEM_RD ##1 RES_VALID)
    else $error("long direct took a pointer read");
  a_word_two_reads: assert property (
    s_ptr_done ##0 state_q == ST_PTR0 ##0 word_ptr |=>
    state_q == ST_PTR1 && MEM_RD)
    else $error("word pointer missed second byte");
  a_byte_one_read: assert property (
    s_ptr_done ##0 state_q == ST_PTR0 ##0 !word_ptr |=> RES_VALID)
    else $error("byte pointer read did not finish");
  a_rel_span: assert property (
    RES_VALID && RES.mode == amg_pkg::AM_REL_D |->
    (RES.target - req_q.next_pc + 16'h0080) <= 16'h00FF)
    else $error("relative target out of span");
  a_rmw_long: assert property (
    RES_VALID && req_q.rmw && RES.mode == amg_pkg::AM_DIR_L |-> RES.rmw_bad)
    else $error("long form accepted for read-modify-write");
  a_ptr_page_zero: assert property (
    s_take |=> MEM_ADDR[15:8] == 8'h00)
    else $error("pointer address outside page zero");

endmodule : amg_addr_gen

// ---- sim/amg_mem_model.sv ----
// amg_mem_model: data memory that answers the generator's pointer reads
// assumes MEM_RD and MEM_ADDR stand until MEM_ACK, all on MCLK
`timescale 1ns/1ps
module amg_mem_model (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic MEM_RD,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [1:0] LAT,
  output logic [7:0] MEM_RDATA,
  output logic MEM_ACK
);
  logic [1:0] wait_q = 2'h0;
  initial MEM_ACK = 1'b0;
  initial MEM_RDATA = 8'h00;
  // ack after LAT wait cycles; data bus scrambles outside the ack
  always @(negedge MCLK) begin
    if (!RST_N || !MEM_RD || MEM_ACK || wait_q < LAT) begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      wait_q <= (MEM_RD && !MEM_ACK) ? wait_q + 2'h1 : 2'h0;
    end else begin
      MEM_ACK <= 1'b1;
      MEM_RDATA <= MEM_ADDR[7:0] ^ MEM_ADDR[15:8] ^ 8'h5A;
      wait_q <= 2'h0;
    end
  end
endmodule : amg_mem_model

// ---- sim/addressing_mode_address_generator_tb_top.sv ----
// addressing_mode_address_generator_tb_top: directed checks of amg_addr_gen
// assumes the memory model holds a ^ (a >> 8) ^ 5A at each address a
`timescale 1ns/1ps
module addressing_mode_address_generator_tb_top;
  logic mclk, rst_n, req_valid, req_ready, mem_rd, mem_ack, res_valid;
  logic rmw_v;
  logic [1:0] lat;
  logic [7:0] mem_rdata, x_v, y_v;
  logic [15:0] mem_addr, pc_v;
  amg_pkg::amg_req_t req;
  amg_pkg::amg_res_t res;
  int error_cnt = 0;
  int samples_checked = 0;
  int rd_cnt = 0;
  int rd_base = 0;
  amg_addr_gen amg_addr_gen_i (.MCLK(mclk), .RST_N(rst_n),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata),
    .MEM_ACK(mem_ack), .RES_VALID(res_valid), .RES(res));
  amg_mem_model amg_mem_model_i (.MCLK(mclk), .RST_N(rst_n),
    .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .LAT(lat),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack));
  // core clock and a count of completed pointer reads
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (mem_rd && mem_ack) rd_cnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // one request: wait ready, hold valid over one edge, wait the result
  task automatic go(input amg_pkg::amg_mode_t m, input amg_pkg::amg_pre_t p,
    input logic [7:0] b1, input logic [7:0] b2);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    req = '{m, p, rmw_v, b1, b2, x_v, y_v, pc_v};
    req_valid = 1'b1;
    rd_base = rd_cnt;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (res_valid !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(res_valid, 1'b1);
  endtask : go
  task automatic ex(input amg_pkg::amg_mode_t m, input logic [15:0] ea,
    input logic [2:0] len, input int nrd);
    chk(res.mode, m);
    chk(res.ea, ea);
    chk(res.len, len);
    chk(rd_cnt - rd_base, nrd);
  endtask : ex
  task automatic t_plain();
    go(amg_pkg::AM_INH, amg_pkg::PRE_NONE, 8'h12, 8'h34);
    chk(res.len, 3'h1);
    go(amg_pkg::AM_IMM, amg_pkg::PRE_NONE, 8'h55, 8'h34);
    chk(res.operand, 8'h55);
    chk(res.len, 3'h2);
    go(amg_pkg::AM_DIR_S, amg_pkg::PRE_NONE, 8'hFF, 8'h34);
    ex(amg_pkg::AM_DIR_S, 16'h00FF, 3'h2, 0);
    go(amg_pkg::AM_DIR_L, amg_pkg::PRE_NONE, 8'hAB, 8'hCD);
    ex(amg_pkg::AM_DIR_L, 16'hABCD, 3'h3, 0);
    $display("test plain done");
  endtask : t_plain
  task automatic t_index();
    go(amg_pkg::AM_IDX0, amg_pkg::PRE_NONE, 8'h00, 8'h00);
    ex(amg_pkg::AM_IDX0, 16'h003C, 3'h1, 0);
    go(amg_pkg::AM_IDX0, amg_pkg::y_substitute_prefix, 8'h00, 8'h00);
    ex(amg_pkg::AM_IDX0, 16'h00C3, 3'h2, 0);
    x_v = 8'hFF;
    go(amg_pkg::AM_IDX_S, amg_pkg::PRE_NONE, 8'hFF, 8'h00);
    ex(amg_pkg::AM_IDX_S, 16'h01FE, 3'h2, 0);
    x_v = 8'h02;
    go(amg_pkg::AM_IDX_L, amg_pkg::PRE_NONE, 8'hFF, 8'hFF);
    ex(amg_pkg::AM_IDX_L, 16'h0001, 3'h3, 0);
    $display("test index done");
  endtask : t_index
  // slow memory: pointers at the page-zero edge cross to 0100
  task automatic t_indirect();
    lat = 2'h2;
    x_v = 8'hFF;
    y_v = 8'h10;
    go(amg_pkg::AM_DIR_S, amg_pkg::indirect_prefix, 8'h33, 8'h00);
    ex(amg_pkg::AM_IND_S, 16'h0069, 3'h3, 1);
    go(amg_pkg::AM_DIR_L, amg_pkg::indirect_prefix, 8'hFF, 8'h00);
    ex(amg_pkg::AM_IND_L, 16'hA55B, 3'h3, 2);
    go(amg_pkg::AM_IDX_S, amg_pkg::indirect_prefix, 8'hA5, 8'h00);
    ex(amg_pkg::AM_IIX_S, 16'h01FE, 3'h3, 1);
    go(amg_pkg::AM_IDX_L, amg_pkg::y_indirect_prefix, 8'hFF, 8'h00);
    ex(amg_pkg::AM_IIX_L, 16'hA56B, 3'h3, 2);
    go(amg_pkg::AM_IDX_S, amg_pkg::y_indirect_prefix, 8'hA5, 8'h00);
    ex(amg_pkg::AM_IIX_S, 16'h010F, 3'h3, 1);
    go(amg_pkg::AM_IDX_L, amg_pkg::indirect_prefix, 8'hFF, 8'h00);
    ex(amg_pkg::AM_IIX_L, 16'hA65A, 3'h3, 2);
    lat = 2'h0;
    $display("test indirect done");
  endtask : t_indirect
  task automatic t_branch();
    go(amg_pkg::AM_REL_D, amg_pkg::PRE_NONE, 8'h80, 8'h00);
    chk(res.target, 16'h0F80);
    chk(res.len, 3'h2);
    go(amg_pkg::AM_REL_D, amg_pkg::PRE_NONE, 8'h7F, 8'h00);
    chk(res.target, 16'h107F);
    go(amg_pkg::AM_REL_D, amg_pkg::indirect_prefix, 8'hDA, 8'h00);
    chk(res.target, 16'h0F80);
    chk(res.mode, amg_pkg::AM_REL_I);
    go(amg_pkg::AM_BIT_D, amg_pkg::PRE_NONE, 8'h10, 8'h00);
    ex(amg_pkg::AM_BIT_D, 16'h0010, 3'h2, 0);
    go(amg_pkg::AM_BIT_D, amg_pkg::indirect_prefix, 8'h10, 8'h00);
    ex(amg_pkg::AM_BIT_I, 16'h004A, 3'h3, 1);
    go(amg_pkg::AM_BIT_DR, amg_pkg::PRE_NONE, 8'h10, 8'hFE);
    ex(amg_pkg::AM_BIT_DR, 16'h0010, 3'h3, 0);
    chk(res.target, 16'h0FFE);
    go(amg_pkg::AM_BIT_DR, amg_pkg::indirect_prefix, 8'h10, 8'h02);
    chk(res.len, 3'h4);
    $display("test branch done");
  endtask : t_branch
  task automatic t_refuse();
    rmw_v = 1'b1;
    go(amg_pkg::AM_DIR_L, amg_pkg::PRE_NONE, 8'h12, 8'h34);
    chk(res.rmw_bad, 1'b1);
    go(amg_pkg::AM_IDX_S, amg_pkg::PRE_NONE, 8'h12, 8'h00);
    chk(res.rmw_bad, 1'b0);
    rmw_v = 1'b0;
    go(amg_pkg::AM_IDX0, amg_pkg::indirect_prefix, 8'h00, 8'h00);
    chk(res.bad_combo, 1'b1);
    chk(res.mode, amg_pkg::AM_IDX0);
    go(amg_pkg::AM_DIR_S, amg_pkg::y_indirect_prefix, 8'h33, 8'h00);
    chk(res.bad_combo, 1'b1);
    chk(res.mode, amg_pkg::AM_DIR_S);
    $display("test refuse done");
  endtask : t_refuse
  // reset in mid-run while a word pointer read waits on slow memory
  task automatic t_reset();
    lat = 2'h2;
    @(negedge mclk);
    req = '{amg_pkg::AM_DIR_L, amg_pkg::indirect_prefix, rmw_v, 8'h40,
            8'h00, x_v, y_v, pc_v};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    chk(mem_rd, 1'b1);
    chk(mem_addr, 16'h0040);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk(mem_rd, 1'b0);
    chk(mem_addr, 16'h0000);
    chk(res.len, 3'h0);
    chk(res.bad_combo, 1'b0);
    chk(req_ready, 1'b1);
    rst_n = 1'b1;
    go(amg_pkg::AM_DIR_L, amg_pkg::indirect_prefix, 8'hFF, 8'h00);
    ex(amg_pkg::AM_IND_L, 16'hA55B, 3'h3, 2);
    lat = 2'h0;
    $display("test reset done");
  endtask : t_reset
  // watchdog cuts a hang short
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end
  // reset for five cycles, check idle outputs, then run the tests
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    lat = 2'h0;
    rmw_v = 1'b0;
    x_v = 8'h3C;
    y_v = 8'hC3;
    pc_v = 16'h1000;
    repeat (5) @(negedge mclk);
    chk(req_ready, 1'b1);
    chk(mem_rd, 1'b0);
    chk(res_valid, 1'b0);
    rst_n = 1'b1;
    t_plain();
    t_index();
    t_indirect();
    t_branch();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : addressing_mode_address_generator_tb_top
